/* File: design/angle_readout.sv */
// angle register file, serial readout and pwm output of the angle sensor
`timescale 1ns/1ps
`default_nettype none
// Operation
// - address angle_short_with_status reads zero, error, low supply, parity, 12-bit angle
// - address angle_long reads zero over the 15-bit angle
// - short word always carries three status bits; address picks resolution
// - pwm uses 12-bit angle; encoder and commutation use 15-bit angle
// - main angle register refreshes once per microsecond
// - read data captured at first serial edge, then held for frame
// - pwm latches angle once at each period start, at rising edge
// - secondary-path angle register updates every 32 microseconds
// - field strength at field_strength updates every 128 microseconds
// - power-up reloads shadow from nonvolatile memory, registers to default
// - power-up clears write address field and applies stored zero offset
// - duty cycle linear in angle from 5% to 95%
// - first 5% high, last 5% low, middle scales with angle
// - largest duty is 4095/4096 of span plus lead-in
// - carrier chosen by step index 0-15 and band 0-7
// - carrier follows the band-by-index table, 3125 Hz down to 98 Hz
// - pwm pin is open drain, high from external pull-up
// - zero offset subtracted from angle before every output
module angle_readout #(
	parameter int ZCD_CYCLES = angle_readout_pkg::ZCD_CYCLES,
	parameter int FIELD_CYCLES = angle_readout_pkg::FIELD_CYCLES,
	parameter int INIT_CYCLES = angle_readout_pkg::INIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [14:0] mainAngle,
	input wire logic [14:0] zcdAngle,
	input wire logic [15:0] fieldIn,
	input wire logic generalErrorFlag,
	input wire logic lowSupplyFlag,
	input wire angle_readout_pkg::nvm_cfg_t nvmCfg,
	input wire angle_readout_pkg::serial_req_t serialReq,
	output logic [15:0] rdData,
	output logic [7:0] writeAdr,
	output logic ready,
	output logic [14:0] encAngle,
	output logic pwmPeriodStart,
	output logic pwmPinOut,
	output logic pwmPinOe
);
	angle_readout_pkg::boot_state_t state;
	angle_readout_pkg::nvm_cfg_t shadow;
	logic [19:0] initCnt;
	logic [7:0] angleCnt;
	logic [19:0] zcdCnt;
	logic [19:0] fieldCnt;
	logic angleTick;
	logic zcdTick;
	logic fieldTick;
	logic [14:0] angleLong;
	logic [14:0] angleZcd;
	logic [15:0] fieldStrength;
	logic errLatch;
	logic lowLatch;
	logic [14:0] offsetMain;
	logic [14:0] offsetZcd;
	logic [15:0] shortWord;
	logic [11:0] angleShort;
	logic [15:0] readMux;

	// boot sequence: wait out initialisation, then copy nonvolatile config
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= angle_readout_pkg::ST_INIT;
			initCnt <= 20'h00000;
		end else begin
			case (state)
				angle_readout_pkg::ST_INIT: begin
					if (initCnt >= 20'(INIT_CYCLES - 1)) begin
						state <= angle_readout_pkg::ST_LOAD;
					end else begin
						initCnt <= initCnt + 20'h00001;
					end
				end
				angle_readout_pkg::ST_LOAD: begin
					state <= angle_readout_pkg::ST_RUN;
				end
				angle_readout_pkg::ST_RUN: begin
					state <= angle_readout_pkg::ST_RUN;
				end
				default: begin
					state <= angle_readout_pkg::ST_INIT;
				end
			endcase
		end
	end

	assign ready = (state == angle_readout_pkg::ST_RUN);

	// shadow copy of the nonvolatile config, taken after reset release
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shadow <= '0;
		end else if (state == angle_readout_pkg::ST_LOAD) begin
			shadow <= nvmCfg;
		end
	end

	// zero-position offset applied to both angle paths, modulo a turn
	assign offsetMain = mainAngle - shadow.zeroOffset;
	assign offsetZcd = zcdAngle - shadow.zeroOffset;

	// update ticks of the main path, secondary path and field reading
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			angleCnt <= 8'h00;
		end else if (!ready || angleTick) begin
			angleCnt <= 8'h00;
		end else begin
			angleCnt <= angleCnt + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			zcdCnt <= 20'h00000;
		end else if (!ready || zcdTick) begin
			zcdCnt <= 20'h00000;
		end else begin
			zcdCnt <= zcdCnt + 20'h00001;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fieldCnt <= 20'h00000;
		end else if (!ready || fieldTick) begin
			fieldCnt <= 20'h00000;
		end else begin
			fieldCnt <= fieldCnt + 20'h00001;
		end
	end

	assign angleTick = ready
		&& (angleCnt == 8'(angle_readout_pkg::ANGLE_CYCLES - 1));
	assign zcdTick = ready && (zcdCnt == 20'(ZCD_CYCLES - 1));
	assign fieldTick = ready && (fieldCnt == 20'(FIELD_CYCLES - 1));

	// main angle and its status flags refresh together
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			angleLong <= angle_readout_pkg::ANGLE_RESET;
			errLatch <= 1'b0;
			lowLatch <= 1'b0;
		end else if (angleTick) begin
			angleLong <= offsetMain;
			errLatch <= generalErrorFlag;
			lowLatch <= lowSupplyFlag;
		end
	end

	// secondary-path angle register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			angleZcd <= angle_readout_pkg::ANGLE_RESET;
		end else if (zcdTick) begin
			angleZcd <= offsetZcd;
		end
	end

	// field strength register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fieldStrength <= angle_readout_pkg::WORD_RESET;
		end else if (fieldTick) begin
			fieldStrength <= fieldIn;
		end
	end

	// short angle drops the low bits of the long one
	assign angleShort = angleLong[angle_readout_pkg::LONG_ANGLE_MSB:
		angle_readout_pkg::SHORT_DROP];
	assign encAngle = angleLong;

	// short word with status; parity makes the word's xor zero
	always_comb begin
		shortWord = angle_readout_pkg::WORD_RESET;
		shortWord[angle_readout_pkg::SHORT_ANGLE_MSB:0] = angleShort;
		shortWord[angle_readout_pkg::ERR_BIT] = errLatch;
		shortWord[angle_readout_pkg::LOW_SUPPLY_BIT] = lowLatch;
		shortWord[angle_readout_pkg::PARITY_BIT] =
			^{errLatch, lowLatch, angleShort};
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		case (serialReq.addr)
			angle_readout_pkg::ADDR_ANGLE_SHORT: begin
				readMux = shortWord;
			end
			angle_readout_pkg::ADDR_ANGLE_LONG: begin
				readMux = {1'b0, angleLong};
			end
			angle_readout_pkg::ADDR_FIELD: begin
				readMux = fieldStrength;
			end
			angle_readout_pkg::ADDR_ZCD_ANGLE: begin
				readMux = {1'b0, angleZcd};
			end
			angle_readout_pkg::ADDR_WRITE_ADR: begin
				readMux = {8'h00, writeAdr};
			end
			default: begin
				readMux = angle_readout_pkg::WORD_RESET;
			end
		endcase
	end

	// read word frozen at the frame's first serial edge until the next read frame
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= angle_readout_pkg::WORD_RESET;
		end else if (serialReq.frameStart && !serialReq.write) begin
			rdData <= readMux;
		end
	end

	// extended write address field, the only writable register here
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			writeAdr <= angle_readout_pkg::WRITE_ADR_RESET;
		end else if (!ready) begin
			writeAdr <= angle_readout_pkg::WRITE_ADR_RESET;
		end else if (serialReq.frameStart && serialReq.write
			&& serialReq.addr == angle_readout_pkg::ADDR_WRITE_ADR) begin
			writeAdr <= serialReq.wdata[7:0];
		end
	end

	// pwm output on the 12-bit angle, carrier from the shadow config
	pwm_carrier u_pwm (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.enable(ready),
		.angle12(angleShort),
		.carrierStepIndex(shadow.carrierStepIndex),
		.carrierBand(shadow.carrierBand),
		.periodStart(pwmPeriodStart),
		.pinOut(pwmPinOut),
		.pinOe(pwmPinOe)
	);
endmodule // angle_readout
`default_nettype wire

/* File: design/angle_readout_pkg.sv */
// shared constants, layouts and types of the angle readout and pwm block
package angle_readout_pkg;

	// serial register addresses
	localparam logic [5:0] ADDR_ANGLE_SHORT = 6'h20;
	localparam logic [5:0] ADDR_FIELD = 6'h2a;
	localparam logic [5:0] ADDR_ZCD_ANGLE = 6'h2e;
	localparam logic [5:0] ADDR_ANGLE_LONG = 6'h32;
	localparam logic [5:0] ADDR_WRITE_ADR = 6'h3c;

	// field positions of the short angle word
	localparam int ERR_BIT = 14;
	localparam int LOW_SUPPLY_BIT = 13;
	localparam int PARITY_BIT = 12;
	localparam int SHORT_ANGLE_MSB = 11;
	localparam int LONG_ANGLE_MSB = 14;
	localparam int SHORT_DROP = 3;

	// reset values
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] WRITE_ADR_RESET = 8'h00;
	localparam logic [14:0] ANGLE_RESET = 15'h0000;

	// timing: printed figures and derived cycle counts
	localparam int CLK_PERIOD_PS = 5000;
	localparam int ANGLE_PERIOD_NS = 1000;
	localparam int ZCD_PERIOD_NS = 32000;
	localparam int FIELD_PERIOD_NS = 128000;
	localparam int INIT_TIME_NS = 300000;
	localparam int ANGLE_CYCLES = ANGLE_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int ZCD_CYCLES = ZCD_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int FIELD_CYCLES = FIELD_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int INIT_CYCLES = INIT_TIME_NS * 1000 / CLK_PERIOD_PS;

	// pwm carrier: period = quarters of 2.5 us
	localparam int QUARTER_NS = 2500;
	localparam int QUARTER_CYCLES = QUARTER_NS * 1000 / CLK_PERIOD_PS;
	localparam int LEAD_PER_QUARTER = QUARTER_CYCLES / 20;
	localparam int SPAN_PER_QUARTER = QUARTER_CYCLES * 9 / 10;
	localparam logic [11:0] PERIOD_BASE_Q = 12'h070;
	localparam int BAND_SHIFT = 4;
	localparam int ANGLE_FRAC_BITS = 12;

	// nonvolatile configuration copied into shadow at power-up
	typedef struct packed {
		logic [14:0] zeroOffset;
		logic [3:0] carrierStepIndex;
		logic [2:0] carrierBand;
	} nvm_cfg_t;

	// one serial frame event, sampled on its first serial clock edge
	typedef struct packed {
		logic frameStart;
		logic write;
		logic [5:0] addr;
		logic [15:0] wdata;
	} serial_req_t;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} boot_state_t;

endpackage

/* File: design/pwm_carrier.sv */
// open-drain pwm generator with angle-proportional duty cycle
`timescale 1ns/1ps
`default_nettype none
module pwm_carrier (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic [11:0] angle12,
	input wire logic [3:0] carrierStepIndex,
	input wire logic [2:0] carrierBand,
	output logic periodStart,
	output logic pinOut,
	output logic pinOe
);
	logic [11:0] quarters;
	logic [20:0] periodCycles;
	logic [20:0] leadCycles;
	logic [33:0] spanProduct;
	logic [20:0] highCycles;
	logic [20:0] periodLatch;
	logic [20:0] highLatch;
	logic [20:0] cnt;
	logic atEnd;

	// period from band and step: base + 2^(band+4) + step<<band quarters
	always_comb begin
		quarters = angle_readout_pkg::PERIOD_BASE_Q
			+ (12'h001 << (4'(carrierBand)
			+ 4'(angle_readout_pkg::BAND_SHIFT)))
			+ (12'(carrierStepIndex) << carrierBand);
		periodCycles = 21'(quarters * 21'(angle_readout_pkg::QUARTER_CYCLES));
		leadCycles = 21'(quarters * 21'(angle_readout_pkg::LEAD_PER_QUARTER));
		spanProduct = 34'(quarters) * 34'(angle_readout_pkg::SPAN_PER_QUARTER)
			* 34'(angle12);
		// 5% lead plus angle/4096 of the 90% span
		highCycles = leadCycles
			+ 21'(spanProduct >> angle_readout_pkg::ANGLE_FRAC_BITS);
	end

	assign atEnd = (cnt == periodLatch - 21'h000001);
	assign periodStart = enable && (atEnd || periodLatch == 21'h000000);
	assign pinOut = 1'b0;

	// period counter; angle and carrier are latched at each period start
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 21'h000000;
			periodLatch <= 21'h000000;
			highLatch <= 21'h000000;
		end else if (!enable) begin
			cnt <= 21'h000000;
			periodLatch <= 21'h000000;
			highLatch <= 21'h000000;
		end else if (periodStart) begin
			cnt <= 21'h000000;
			periodLatch <= periodCycles;
			highLatch <= highCycles;
		end else begin
			cnt <= cnt + 21'h000001;
		end
	end

	// open drain: release for the high part, pull low for the rest
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pinOe <= 1'b1;
		end else if (!enable) begin
			pinOe <= 1'b1;
		end else if (periodStart) begin
			pinOe <= 1'b0;
		end else begin
			pinOe <= (cnt + 21'h000001 >= highLatch);
		end
	end
endmodule // pwm_carrier
`default_nettype wire

/* File: verification/angle_readout_asserts.sv */
// port assertions of the angle readout block
`timescale 1ns/1ps
`default_nettype none
module angle_readout_asserts #(parameter int INIT_CYCLES = 10) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire angle_readout_pkg::serial_req_t serialReq,
	input wire logic [15:0] rdData,
	input wire logic [7:0] writeAdr,
	input wire logic ready,
	input wire logic pwmPeriodStart,
	input wire logic pwmPinOut,
	input wire logic pwmPinOe
);
	logic [15:0] bootCnt;
	logic wrTake;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// accepted write of the write address field
	assign wrTake = serialReq.frameStart && serialReq.write && ready
		&& serialReq.addr == angle_readout_pkg::ADDR_WRITE_ADR;
	// cycles spent booting since reset release
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bootCnt <= 16'h0000;
		end else if (!ready) begin
			bootCnt <= bootCnt + 16'h0001;
		end
	end
	chk_pin_drain: assert property (pwmPinOut == 1'b0)
		else $error("pwm pin driven high");
	chk_rd_hold: assert property ($changed(rdData) |->
		$past(serialReq.frameStart && !serialReq.write))
		else $error("read word changed without a read");
	chk_wadr_cause: assert property (
		$changed(writeAdr) |-> $past(wrTake))
		else $error("write address changed without a write");
	chk_wadr_take: assert property (wrTake |=>
		writeAdr == $past(serialReq.wdata[7:0]))
		else $error("write address not taken");
	chk_boot_time: assert property ($rose(ready) |->
		bootCnt == INIT_CYCLES + 1)
		else $error("boot length wrong");
	chk_ready_keep: assert property (ready |=> ready)
		else $error("ready dropped");
	chk_lead_high: assert property (
		pwmPeriodStart |=> !pwmPinOe [*8])
		else $error("lead-in not high");
	chk_tail_low: assert property (pwmPeriodStart |->
		pwmPinOe && $past(pwmPinOe))
		else $error("tail not low");
	chk_rise_start: assert property (
		$fell(pwmPinOe) |-> $past(pwmPeriodStart))
		else $error("rising edge off period start");
endmodule // angle_readout_asserts
`default_nettype wire

/* File: verification/host_model.sv */
// host side: serial frames and pwm line measurement
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [15:0] rdData,
	input wire logic pwmPinOut,
	input wire logic pwmPinOe,
	input wire logic pwmPeriodStart,
	output var angle_readout_pkg::serial_req_t serialReq,
	output var int highLen,
	output var int perLen
);
	logic line;
	logic started;
	int cnt;
	int hi;
	// a released pin is pulled up externally
	assign line = pwmPinOe ? pwmPinOut : 1'b1;
	initial serialReq = '0;
	// length and high time of each whole carrier period
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			started <= 1'b0;
			cnt <= 0;
			hi <= 0;
			perLen <= 0;
			highLen <= 0;
		end else if (pwmPeriodStart) begin
			if (started) begin
				perLen <= cnt;
				highLen <= hi;
			end
			started <= 1'b1;
			cnt <= 1;
			hi <= 0;
		end else begin
			cnt <= cnt + 1;
			if (line) hi <= hi + 1;
		end
	end
	// one serial frame, answer taken in the following cycle
	task automatic frame(input logic wr, input logic [5:0] addr,
		input logic [15:0] wdata, output logic [15:0] data);
		@(posedge ref_clk);
		serialReq <= '{1'b1, wr, addr, wdata};
		@(posedge ref_clk);
		serialReq.frameStart <= 1'b0;
		@(negedge ref_clk);
		data = rdData;
	endtask
endmodule // host_model
`default_nettype wire

/* File: verification/tb_angle_readout.sv */
// self-checking bench of the angle readout block
`timescale 1ns/1ps
`default_nettype none
module tb_angle_readout;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [14:0] mainAngle, zcdAngle, encAngle;
	logic [15:0] fieldIn, rdData, got, old;
	logic generalErrorFlag, lowSupplyFlag, ready, pinOut, pinOe, start;
	logic [7:0] writeAdr, expAdr;
	logic [31:0] seed = 32'h8a80;
	logic [31:0] r;
	angle_readout_pkg::nvm_cfg_t nvmCfg;
	angle_readout_pkg::serial_req_t serialReq;
	int err_count = 0;
	int checked = 0;
	int highLen, perLen, expPer;
	logic [5:0] addrs[$] = '{6'h20, 6'h32, 6'h2a, 6'h2e, 6'h15, 6'h3c};
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	angle_readout #(.ZCD_CYCLES(20), .FIELD_CYCLES(40), .INIT_CYCLES(10)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .mainAngle(mainAngle),
		.zcdAngle(zcdAngle), .fieldIn(fieldIn), .nvmCfg(nvmCfg),
		.generalErrorFlag(generalErrorFlag), .lowSupplyFlag(lowSupplyFlag),
		.serialReq(serialReq), .rdData(rdData), .writeAdr(writeAdr),
		.ready(ready), .encAngle(encAngle), .pwmPeriodStart(start),
		.pwmPinOut(pinOut), .pwmPinOe(pinOe));
	host_model host (.ref_clk(ref_clk), .nrst(nrst), .rdData(rdData),
		.pwmPinOut(pinOut), .pwmPinOe(pinOe), .pwmPeriodStart(start),
		.serialReq(serialReq), .highLen(highLen), .perLen(perLen));
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// bench model of every readable word
	function automatic logic [15:0] model(input logic [5:0] a);
		logic [14:0] ang;
		logic [14:0] zcd;
		logic [15:0] w;
		ang = mainAngle - nvmCfg.zeroOffset;
		zcd = zcdAngle - nvmCfg.zeroOffset;
		w = 16'h0000;
		if (a == 6'h20) w = {1'b0, generalErrorFlag, lowSupplyFlag, 1'b0,
			ang[14:3]};
		if (a == 6'h20) w[12] = ^w;
		if (a == 6'h32) w = {1'b0, ang};
		if (a == 6'h2a) w = fieldIn;
		if (a == 6'h2e) w = {1'b0, zcd};
		if (a == 6'h3c) w = {8'h00, expAdr};
		return w;
	endfunction
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic waitReady();
		for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge ref_clk);
	endtask
	// main sequence
	initial begin
		{mainAngle, zcdAngle, fieldIn, generalErrorFlag, lowSupplyFlag} = '0;
		r = rnd();
		nvmCfg = {r[14:0], 7'h00};
		expAdr = 8'h00;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		host.frame(1'b0, 6'h20, 16'h0000, got);
		check(got, 16'h0000);
		host.frame(1'b1, 6'h3c, 16'h00a5, got);
		check(writeAdr, 8'h00);
		waitReady();
		repeat (3) begin
			r = rnd();
			host.frame(1'b1, 6'h3c, r[15:0], got);
			expAdr = r[7:0];
			host.frame(1'b1, 6'h20, ~r[15:0], got);
			@(posedge ref_clk);
			fieldIn <= r[31:16];
			r = rnd();
			mainAngle <= r[14:0];
			zcdAngle <= r[29:15];
			generalErrorFlag <= r[30];
			lowSupplyFlag <= r[31];
			repeat (250) @(posedge ref_clk);
			#1 check({1'b0, encAngle}, model(6'h32));
			foreach (addrs[i]) begin
				host.frame(1'b0, addrs[i], 16'h0000, got);
				check(got, model(addrs[i]));
			end
			host.frame(1'b0, 6'h20, 16'h0000, old);
			check(old, model(6'h20));
			@(posedge ref_clk);
			mainAngle <= ~mainAngle;
			repeat (250) @(posedge ref_clk);
			#1 check(rdData, old);
			host.frame(1'b0, 6'h20, 16'h0000, got);
			check(got, model(6'h20));
		end
		for (int i = 0; i < 70000 && perLen == 0; i++) @(posedge ref_clk);
		expPer = 200000000 / 3125;
		check(perLen, expPer);
		check(highLen, expPer / 20);
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 check(writeAdr, 8'h00);
		check(rdData, 16'h0000);
		@(posedge ref_clk);
		nrst <= 1'b1;
		waitReady();
		check(ready, 1'b1);
		conclude();
	end
	// watchdog
	initial begin
		#450000;
		err_count++;
		conclude();
	end
endmodule // tb_angle_readout
bind angle_readout angle_readout_asserts #(.INIT_CYCLES(INIT_CYCLES)) chk (
	.ref_clk(ref_clk), .nrst(nrst), .serialReq(serialReq),
	.rdData(rdData), .writeAdr(writeAdr), .ready(ready),
	.pwmPeriodStart(pwmPeriodStart), .pwmPinOut(pwmPinOut),
	.pwmPinOe(pwmPinOe));
`default_nettype wire
